// file: hdl/ppm_map.vh
// What this block does
// - After reset port-1 pins are plain I/O, direction and select cleared.
// - Serial enable on pin 6: serial data out (SPI) or clock line (I2C).
// - Serial enable on pin 7: serial data in (SPI) or data line (I2C).
// - Outside JTAG mode, analog enable turns off the pin's output driver and input buffer.
// - JTAG mode disables pull resistors on pins JTAG owns.
// - Selected negative converter input without analog enable ties to ground.
// - In JTAG mode pin 7 direction comes from the JTAG logic.
// - Port-2 pin 6 resets to crystal input: direction 0, select 1.
// - Crystal input acts as digital clock input when source select is 11.
// - Port-2 pin 7 drives oscillator output while its select and direction bits are both set; select without direction drives 0.
`ifndef PPM_MAP_VH
`define PPM_MAP_VH
`define PPM_P1_DIR_RST 4'h0
`define PPM_P1_SEL_RST 4'h0
`define PPM_P2_DIR_RST 2'h2
`define PPM_P2_SEL_RST 2'h3
`define PPM_LF_EXT_CLK 2'h3
`define PPM_CH_A2 3'h2
`define PPM_CH_A3 3'h3
`endif

// file: hdl/ppm_port_pin_function_mux.v
`timescale 1ns/100ps
`include "ppm_map.vh"
module ppm_port_pin_function_mux (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Register writes from the core (bit 0 = pin 4 / pin 6)
  input wire p1_wr_i,
  input wire [3:0] port1_direction_i,
  input wire [3:0] port1_function_select_i,
  input wire [3:0] port1_out_i,
  input wire p2_wr_i,
  input wire [1:0] port2_direction_i,
  input wire [1:0] port2_function_select_i,
  input wire [1:0] port2_out_i,
  // Mode controls
  input wire [3:0] serial_pin_enable_i,
  input wire [3:0] analog_input_enable_i,
  input wire [2:0] analog_channel_select_i,
  input wire [1:0] lf_osc_source_select_i,
  input wire jtag_mode_i,
  input wire spi_mode_i,
  // Peripheral signals
  input wire sub_main_clock_out_i,
  input wire timer_out0_i,
  input wire timer_out1_i,
  input wire serial_clk_out_i,
  input wire serial_clk_oe_i,
  input wire serial_sdo_i,
  input wire serial_scl_oe_i,
  input wire serial_sda_oe_i,
  input wire jtag_tdo_i,
  input wire jtag_tdo_en_i,
  input wire osc_out_i,
  // Pads: outputs, output enables (low drives), inputs
  output reg [3:0] p1_pad_o,
  output reg [3:0] p1_pad_oe_n_o,
  output reg [3:0] p1_pull_en_o,
  output reg [3:0] p1_ana_conn_o,
  input wire [3:0] p1_pad_i,
  output reg [1:0] p2_pad_o,
  output reg [1:0] p2_pad_oe_n_o,
  input wire [1:0] p2_pad_i,
  // Core-side results
  output reg [3:0] port1_in_o,
  output reg [1:0] port2_in_o,
  output reg [1:0] port1_dir_q_o,
  output reg serial_sdi_o,
  output reg serial_clk_in_o,
  output reg timer_cci1b_o,
  output reg jtag_tck_o,
  output reg jtag_tms_o,
  output reg jtag_tdi_o,
  output reg crystal_in_o,
  output reg crystal_in_digital_o,
  output reg neg_input_gnd_o,
  output reg osc_out_conn_o
);

////////////////////////////////////////////////////////////////////////
reg [3:0] p1_dir_q;
reg [3:0] p1_sel_q;
reg [1:0] p2_dir_q;
reg [1:0] p2_sel_q;
reg [3:0] s1_q, s2_q, s3_q, p1_in_q;
reg [1:0] t1_q, t2_q, t3_q, p2_in_q;
integer i;
integer k;
reg cap_ok;

////////////////////////////////////////////////////////////////////////
// Helpers

// A pin level is taken only once two filter stages agree
function filt_bit;
  input hold;
  input mid;
  input last;
  filt_bit = (mid == last) ? last : hold;
endfunction

// Serial unit owns a pin only when JTAG and analog leave it alone
function serial_owns;
  input jtag;
  input ana;
  input ser;
  serial_owns = ~jtag & ~ana & ser;
endfunction

// Negative input falls back to ground when its pin is not analog
function neg_tie;
  input chan_hit;
  input ana;
  neg_tie = chan_hit & ~ana;
endfunction

////////////////////////////////////////////////////////////////////////
// Direction and select registers

always @(posedge core_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    p1_dir_q <= `PPM_P1_DIR_RST;
    p1_sel_q <= `PPM_P1_SEL_RST;
    p2_dir_q <= `PPM_P2_DIR_RST;
    p2_sel_q <= `PPM_P2_SEL_RST;
  end else begin
    if (p1_wr_i) begin
      p1_dir_q <= port1_direction_i;
      p1_sel_q <= port1_function_select_i;
    end
    if (p2_wr_i) begin
      p2_dir_q <= port2_direction_i;
      p2_sel_q <= port2_function_select_i;
    end
  end
end

// Pad inputs: three stages, change accepted when stages two and three agree
always @(posedge core_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    s1_q <= 4'h0;
    s2_q <= 4'h0;
    s3_q <= 4'h0;
    p1_in_q <= 4'h0;
    t1_q <= 2'h0;
    t2_q <= 2'h0;
    t3_q <= 2'h0;
    p2_in_q <= 2'h0;
  end else begin
    s1_q <= p1_pad_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    t1_q <= p2_pad_i;
    t2_q <= t1_q;
    t3_q <= t2_q;
    for (i = 0; i < 4; i = i + 1) begin
      p1_in_q[i] <= filt_bit(p1_in_q[i], s2_q[i], s3_q[i]);
    end

    for (i = 0; i < 2; i = i + 1) begin
      p2_in_q[i] <= filt_bit(p2_in_q[i], t2_q[i], t3_q[i]);
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Plain port output/enable from select and direction
reg [3:0] gp_out;
reg [3:0] gp_drv;
reg [3:0] in_ok;
reg neg_sel;
always @* begin
  gp_out = port1_out_i;
  gp_drv = p1_dir_q;
  gp_out[0] = p1_sel_q[0] ? sub_main_clock_out_i : port1_out_i[0];
  gp_drv[0] = p1_dir_q[0];
  gp_out[1] = p1_sel_q[1] ? timer_out0_i : port1_out_i[1];
  gp_out[2] = p1_sel_q[2] ? timer_out1_i : port1_out_i[2];
  // Pin 7 with select and output drives ground; select alone floats
  gp_out[3] = p1_sel_q[3] ? 1'b0 : port1_out_i[3];
  if (p1_sel_q[1] && !p1_dir_q[1]) gp_drv[1] = 1'b0;
  if (p1_sel_q[3] && !p1_dir_q[3]) gp_drv[3] = 1'b0;
  if (p1_sel_q[0] && !p1_dir_q[0]) gp_drv[0] = 1'b0;

  // Pins that no owner claims stay released with pulls on
  p1_pad_o = 4'h0;
  p1_pad_oe_n_o = 4'hF;
  p1_pull_en_o = 4'hF;
  in_ok = 4'hF;

  for (k = 0; k < 4; k = k + 1) begin
    if (jtag_mode_i) begin
      p1_pull_en_o[k] = 1'b0;
      in_ok[k] = 1'b1;
      if (k == 3) begin
        p1_pad_o[k] = jtag_tdo_i;
        p1_pad_oe_n_o[k] = ~jtag_tdo_en_i;
      end
    end else if (analog_input_enable_i[k]) begin
      // Input reads 0 so a floating analog level never reaches the core
      p1_pad_oe_n_o[k] = 1'b1;
      in_ok[k] = 1'b0;
    end else if (serial_pin_enable_i[k] && k != 0) begin
      if (k == 1) begin
        p1_pad_o[k] = serial_clk_out_i;
        p1_pad_oe_n_o[k] = ~serial_clk_oe_i;
      end else if (k == 2) begin
        // SPI drives data; I2C clock is open drain
        p1_pad_o[k] = spi_mode_i ? serial_sdo_i : 1'b0;
        p1_pad_oe_n_o[k] = spi_mode_i ? 1'b0 : ~serial_scl_oe_i;
      end else begin
        p1_pad_o[k] = 1'b0;
        p1_pad_oe_n_o[k] = spi_mode_i ? 1'b1 : ~serial_sda_oe_i;
      end
    end else begin
      p1_pad_o[k] = gp_out[k];
      p1_pad_oe_n_o[k] = ~gp_drv[k];
    end
  end

  p1_ana_conn_o = jtag_mode_i ? 4'h0 : analog_input_enable_i;
  // Negative inputs: A2 sits on pin 5, A3 on pin 7
  neg_sel = neg_tie(analog_channel_select_i == `PPM_CH_A2, analog_input_enable_i[1]);
  neg_sel = neg_sel | neg_tie(analog_channel_select_i == `PPM_CH_A3, analog_input_enable_i[3]);
  neg_input_gnd_o = neg_sel;
end

////////////////////////////////////////////////////////////////////////
// Core-side inputs and port 2
always @* begin
  port1_in_o = p1_in_q & in_ok;
  port1_dir_q_o = p1_dir_q[3:2];
  jtag_tck_o = jtag_mode_i & p1_in_q[0];
  jtag_tms_o = jtag_mode_i & p1_in_q[1];
  jtag_tdi_o = jtag_mode_i & p1_in_q[2];
  serial_clk_in_o = serial_owns(jtag_mode_i, analog_input_enable_i[1], serial_pin_enable_i[1]) & p1_in_q[1];
  serial_sdi_o = serial_owns(jtag_mode_i, analog_input_enable_i[3], serial_pin_enable_i[3]) & p1_in_q[3];
  // Capture input only while the pin is a plain selected input
  cap_ok = ~jtag_mode_i & ~analog_input_enable_i[2] & ~serial_pin_enable_i[2];
  timer_cci1b_o = cap_ok & p1_sel_q[2] & ~p1_dir_q[2] & p1_in_q[2];
  // Crystal pins: pin 6 input, pin 7 oscillator drive while selected with direction set (selected without direction drives 0)
  crystal_in_o = p2_sel_q[0] & ~p2_dir_q[0] & p2_in_q[0];
  crystal_in_digital_o = p2_sel_q[0] & ~p2_dir_q[0] & (lf_osc_source_select_i == `PPM_LF_EXT_CLK);
  osc_out_conn_o = p2_sel_q[1];
  p2_pad_o[0] = p2_sel_q[0] ? timer_out1_i : port2_out_i[0];
  p2_pad_oe_n_o[0] = ~p2_dir_q[0];
  p2_pad_o[1] = p2_sel_q[1] ? (p2_dir_q[1] ? osc_out_i : 1'b0) : port2_out_i[1];
  p2_pad_oe_n_o[1] = p2_sel_q[1] ? 1'b0 : ~p2_dir_q[1];
  port2_in_o = p2_in_q & ~p2_sel_q;
end

endmodule

// file: sim/ppm_chk.sv
`timescale 1ns/100ps
module ppm_chk (
  input wire core_clk_i, rst_n_i, jtag_mode_i, spi_mode_i, serial_sdo_i, serial_sda_oe_i,
  input wire jtag_tdo_en_i, osc_out_i, crystal_in_digital_o, neg_input_gnd_o, osc_out_conn_o,
  input wire [3:0] serial_pin_enable_i, analog_input_enable_i, p1_pad_o, p1_pad_oe_n_o, p1_pull_en_o,
  input wire [2:0] analog_channel_select_i,
  input wire [1:0] lf_osc_source_select_i, p2_pad_o, p2_pad_oe_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [3:0] ae = analog_input_enable_i;
  // Serial only owns a pin that jtag and analog left alone
  wire [3:0] se = serial_pin_enable_i & ~ae & {4{!jtag_mode_i}};
  wire ch2 = analog_channel_select_i == 3'h2;
  wire ch3 = analog_channel_select_i == 3'h3;
  a_analog_undriven: assert property (!jtag_mode_i |-> (ae & ~p1_pad_oe_n_o) == 4'h0) else $error("analog");
  a_jtag_pulls_off: assert property (jtag_mode_i |-> p1_pull_en_o == 4'h0) else $error("pulls");
  a_jtag_tdo_dir: assert property (jtag_mode_i |-> p1_pad_oe_n_o == {!jtag_tdo_en_i, 3'h7}) else $error("tdo");
  a_neg_input_gnd: assert property (neg_input_gnd_o == (ch2 && !ae[1] || ch3 && !ae[3])) else $error("gnd");
  a_spi_data_out: assert property (se[2] && spi_mode_i |-> !p1_pad_oe_n_o[2] && p1_pad_o[2] == serial_sdo_i)
    else $error("sdo");
  a_i2c_data_od: assert property (se[3] && !spi_mode_i |-> p1_pad_oe_n_o[3] == !serial_sda_oe_i) else $error("sda");
  a_crystal_digital: assert property (lf_osc_source_select_i != 2'h3 |-> !crystal_in_digital_o) else $error("xin");
  a_osc_out_drive: assert property (osc_out_conn_o |-> !p2_pad_oe_n_o[1] && p2_pad_o[1] == osc_out_i)
    else $error("osc");
endmodule
bind ppm_port_pin_function_mux ppm_chk ppm_chk_i (.*);

// file: sim/ppm_board.sv
`timescale 1ns/100ps
module ppm_board (
  input wire [3:0] p1_pad_o, p1_pad_oe_n_o, ext1_i,
  input wire [1:0] p2_pad_o, p2_pad_oe_n_o, ext2_i,
  output wire [3:0] p1_pad_i,
  output wire [1:0] p2_pad_i
);
  // Weak board levels, overridden wherever the chip drives
  assign p1_pad_i = ~p1_pad_oe_n_o & p1_pad_o | p1_pad_oe_n_o & ext1_i;
  assign p2_pad_i = ~p2_pad_oe_n_o & p2_pad_o | p2_pad_oe_n_o & ext2_i;
endmodule

// file: sim/ppm_port_pin_function_mux_tb.sv
`timescale 1ns/100ps
module ppm_port_pin_function_mux_tb;
  logic core_clk_i = 1'h0, rst_n_i = 1'h0, p1_wr_i = 1'h0, p2_wr_i = 1'h0, jtag_mode_i = 1'h0, spi_mode_i = 1'h1;
  logic serial_clk_oe_i = 1'h0, serial_sdo_i = 1'h1, serial_scl_oe_i = 1'h0, serial_sda_oe_i = 1'h0;
  logic jtag_tdo_i = 1'h1, jtag_tdo_en_i = 1'h1, osc_out_i = 1'h1, timer_out0_i = 1'h0, timer_out1_i = 1'h0;
  logic sub_main_clock_out_i = 1'h0, serial_clk_out_i = 1'h0;
  logic [3:0] port1_direction_i = 4'h0, port1_function_select_i = 4'h0, port1_out_i = 4'hA, ext1_i = 4'hD;
  logic [3:0] serial_pin_enable_i = 4'h0, analog_input_enable_i = 4'h0;
  logic [2:0] analog_channel_select_i = 3'h0;
  logic [1:0] port2_direction_i = 2'h0, port2_function_select_i = 2'h0, port2_out_i = 2'h0, ext2_i = 2'h1;
  logic [1:0] lf_osc_source_select_i = 2'h0;
  wire [3:0] p1_pad_o, p1_pad_oe_n_o, p1_pull_en_o, p1_ana_conn_o, p1_pad_i, port1_in_o;
  wire [1:0] p2_pad_o, p2_pad_oe_n_o, p2_pad_i, port2_in_o, port1_dir_q_o;
  wire serial_sdi_o, serial_clk_in_o, timer_cci1b_o, jtag_tck_o, jtag_tms_o, jtag_tdi_o, crystal_in_o;
  wire crystal_in_digital_o, neg_input_gnd_o, osc_out_conn_o;
  int miscompares = 0, n_compared = 0;
  ppm_port_pin_function_mux ppm_port_pin_function_mux_i (.*);
  ppm_board ppm_board_i (.*);
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) {timer_out0_i, timer_out1_i, sub_main_clock_out_i, serial_clk_out_i} <=
    {timer_out1_i, sub_main_clock_out_i, serial_clk_out_i, !timer_out0_i};
  task chk(input logic [3:0] g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic w2, input logic [3:0] d, s);
    @(posedge core_clk_i);
    {p2_wr_i, p1_wr_i} <= {w2, !w2};
    {port1_direction_i, port2_direction_i} <= {d, d[1:0]};
    {port1_function_select_i, port2_function_select_i} <= {s, s[1:0]};
    @(posedge core_clk_i);
    {p2_wr_i, p1_wr_i} <= 2'h0;
    @(negedge core_clk_i);
  endtask
  // Pad inputs pass a filter of up to four edges
  task settle;
    repeat (5) @(negedge core_clk_i);
  endtask
  task final_report;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    settle;
    chk(p1_pad_oe_n_o, 4'hF);
    chk(port1_dir_q_o, 2'h0);
    chk(port1_in_o, 4'hD);
    chk(p2_pad_oe_n_o, 2'h1);
    chk(crystal_in_o, 1'h1);
    chk(osc_out_conn_o, 1'h1);
    wr(1'h0, 4'hF, 4'h0);
    chk(p1_pad_oe_n_o, 4'h0);
    chk(p1_pad_o, 4'hA);
    @(posedge core_clk_i) analog_input_enable_i <= 4'hF;
    settle;
    chk(p1_pad_oe_n_o, 4'hF);
    chk(port1_in_o, 4'h0);
    chk(p1_ana_conn_o, 4'hF);
    @(posedge core_clk_i) {analog_input_enable_i, analog_channel_select_i} <= 7'h02;
    @(negedge core_clk_i) chk(neg_input_gnd_o, 1'h1);
    @(posedge core_clk_i) {analog_input_enable_i, analog_channel_select_i} <= 7'h43;
    @(negedge core_clk_i) chk(neg_input_gnd_o, 1'h0);
    @(posedge core_clk_i) {analog_input_enable_i, serial_pin_enable_i, ext1_i} <= 12'h0FF;
    @(negedge core_clk_i) chk(p1_pad_oe_n_o, 4'hA);
    chk(p1_pad_o[2], 1'h1);
    settle;
    chk(serial_sdi_o, 1'h1);
    chk(serial_clk_in_o, 1'h1);
    @(posedge core_clk_i) {spi_mode_i, serial_sda_oe_i} <= 2'h1;
    @(negedge core_clk_i) chk(p1_pad_oe_n_o, 4'h6);
    @(posedge core_clk_i) {jtag_mode_i, ext1_i} <= 5'h11;
    @(negedge core_clk_i) chk(p1_pad_oe_n_o, 4'h7);
    chk(p1_pull_en_o, 4'h0);
    @(posedge core_clk_i) {jtag_tdo_en_i, lf_osc_source_select_i} <= 3'h3;
    @(negedge core_clk_i) chk(p1_pad_oe_n_o, 4'hF);
    chk(crystal_in_digital_o, 1'h1);
    settle;
    chk({jtag_tdi_o, jtag_tms_o, jtag_tck_o}, 3'h1);
    chk(port1_in_o, 4'h1);
    wr(1'h1, 4'h0, 4'h0);
    chk(osc_out_conn_o, 1'h0);
    chk(p2_pad_oe_n_o, 2'h3);
    settle;
    chk(port2_in_o, 2'h1);
    @(posedge core_clk_i) {jtag_mode_i, serial_pin_enable_i, ext1_i} <= 9'h004;
    wr(1'h0, 4'hB, 4'hF);
    chk(p1_pad_oe_n_o, 4'h4);
    chk(p1_pad_o[3], 1'h0);
    chk(p1_pad_o[1:0], {timer_out0_i, sub_main_clock_out_i});
    chk(port1_dir_q_o, 2'h2);
    settle;
    chk(timer_cci1b_o, 1'h1);
    final_report;
  end
endmodule
